/* tb_video_mpts_null_pcr_adjuster.sv */
// Self-checking bench of the null and clock-reference adjuster
`timescale 1ns/10ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("unexpected %s: expected %h seen %h", n, e, g); end end
module tb_video_mpts_null_pcr_adjuster;
  localparam logic [32:0] NULLB = 33'h000001234;
  logic                 clk_sys;
  logic                 rst;
  logic                 in_valid;
  logic                 in_ready;
  vmpa_pkg::vmpa_cfg_t  cfg;
  vmpa_pkg::vmpa_in_t   in_beat;
  vmpa_pkg::vmpa_ts_t   ts;
  vmpa_pkg::vmpa_stat_t stat;
  int                   n_mismatch;
  int                   num_checks;
  int                   n_ins, n_del, n_loss, bi, off;
  logic [7:0]           pk[188];
  logic [7:0]           exp_q[$];

  vmpa_adjuster i_dut (.clk_sys(clk_sys), .rst(rst), .ce(1'b1), .cfg(cfg),
    .in_valid(in_valid), .in_ready(in_ready), .in_beat(in_beat), .ts(ts), .stat(stat));
  vmpa_core_model i_core (.clk_sys(clk_sys), .in_ready(in_ready), .in_valid(in_valid),
    .in_beat(in_beat));

  // ==========================================================================
  // Clock
  initial
  begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  // Null packets owed for a sequence gap, capped at three frames
  function automatic int fill_pkts(input logic [15:0] s, input logic [15:0] p, input int n);
    logic [15:0] gap;
    gap = s - p - 16'h0001;
    fill_pkts = ((gap > 16'h0003) ? 3 : int'(gap)) * n;
  endfunction : fill_pkts

  // Packet kinds: 0 data, 1 with reference, 2 core null, 9 expected fill null
  task automatic add_pkt(input int kind, inout logic [7:0] fb[$]);
    logic [7:0] p[188];
    foreach (p[i]) p[i] = (kind == 9) ? 8'hff : 8'($urandom);
    p[0] = 8'h47;
    p[1] = (kind >= 2) ? 8'h1f : 8'h01;
    p[2] = (kind >= 2) ? 8'hff : 8'h00;
    p[3] = (kind == 1) ? 8'h30 : 8'h10;
    if (kind == 1)
    begin
      p[4]  = 8'hb7;
      p[5]  = 8'h10;
      p[10] = {p[10][7], 6'h3f, 1'b0};
    end
    foreach (p[i])
    begin
      if (kind != 9) fb.push_back(p[i]);
      if (!(cfg.async_mode && kind >= 2)) exp_q.push_back(p[i]);
    end
  endtask : add_pkt

  // Compare one output packet, reference shifted by net null change
  task automatic check_pkt();
    logic [7:0]  e[188];
    logic [32:0] b;
    if (cfg.async_mode && pk[1][4:0] == 5'h1f && pk[2] == 8'hff) return;
    if (exp_q.size() < 188) return;
    foreach (e[i]) e[i] = exp_q.pop_front();
    if (e[3][5] && e[4] != 8'h00 && e[5][4])
    begin
      b = {e[6], e[7], e[8], e[9], e[10][7]} + NULLB * 33'(off);
      {e[6], e[7], e[8], e[9], e[10][7]} = b;
    end
    foreach (e[i]) `CHK("byte", e[i], pk[i])
  endtask : check_pkt

  // Output collector and event counters
  always @(posedge clk_sys)
  begin
    if (rst) bi = 0;
    else
    begin
      n_ins += stat.ins;
      n_del += stat.del;
      n_loss += stat.loss;
      if (ts.valid)
      begin
        if (ts.sop) off = cfg.async_mode ? n_ins - n_del : 0;
        pk[bi] = ts.data;
        bi++;
        if (bi == 188)
        begin
          check_pkt();
          bi = 0;
        end
      end
    end
  end

  // Reset, send six frames, drain and judge
  task automatic run_phase(input logic am, input logic [15:0] s[6], input int n[6],
                           input int k[6], input int loss);
    logic [7:0] fb[$];
    rst <= 1'b1;
    cfg <= '{async_mode: am, rate_step: 32'h40000000, null_pcr: '{base: NULLB, ext: 9'h000}};
    exp_q.delete();
    repeat (5) @(posedge clk_sys);
    n_ins = 0;
    n_del = 0;
    n_loss = 0;
    rst <= 1'b0;
    for (int f = 0; f < 6; f++)
    begin
      fb.delete();
      if (f > 0)
        repeat (fill_pkts(s[f], s[f-1], n[f-1])) add_pkt(9, fb);
      for (int j = 0; j < n[f]; j++)
        add_pkt((k[f] == 1 && j == n[f] - 1) ? 1 : (k[f] == 3 && j % 2 == 0) ? 2 : 0, fb);
      i_core.slow = (k[f] == 4);
      i_core.send_frame(s[f], fb);
    end
    i_core.idle();
    for (int t = 0; t < 40000 && exp_q.size() > 0; t++) @(posedge clk_sys);
    repeat (3000) @(posedge clk_sys);
    `CHK("left", 0, exp_q.size())
    `CHK("loss", loss, n_loss)
    `CHK("del", am, n_del > 0)
    if (am) `CHK("ins", 1'b1, n_ins > 0)
  endtask : run_phase

  // ==========================================================================
  // Main sequence: sync with wrap and losses, then async add and drop
  initial
  begin
    rst = 1'b1;
    cfg = '0;
    n_mismatch = 0;
    num_checks = 0;
    bi = 0;
    off = 0;
    void'($urandom(29460));
    run_phase(1'b0, '{16'hfffe, 16'hffff, 16'h0000, 16'h0002, 16'h0003, 16'h0006},
              '{3, 2, 4, 1, 10, 1}, '{0, 1, 0, 0, 0, 1}, 2);
    run_phase(1'b1, '{16'h1234, 16'h1235, 16'h1236, 16'h1237, 16'h1238, 16'h1239},
              '{10, 10, 4, 3, 10, 2}, '{3, 3, 4, 1, 3, 1}, 0);
    complete_run();
  end

  // Watchdog, well above the expected run of some 65000 cycles
  initial
  begin
    repeat (90000) @(posedge clk_sys);
    n_mismatch++;
    complete_run();
  end

  // Verdict and end of run
  task automatic complete_run();
    if (n_mismatch == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : complete_run
endmodule : tb_video_mpts_null_pcr_adjuster

/* vmpa_adjuster.sv */
// Transport stream de-jitter, lost-frame null fill, rate null add/drop and restamp
`timescale 1ns/10ps

// Behaviour
// - Every multiplex passes the de-jitter FIFO
// - Output paced at configured constant byte rate
// - Async: drop nulls at or above the high mark, add when low
// - Async: shift references only by null changes
// - Sync: no restamp, nulls replace losses and are added when the buffer is empty
// - Sequence gap triggers null packet insertion
// - Nulls per lost frame equal last frame's count
// - Single lost frame: nulls at exact positions
// - Frames carry whole 188-byte packets, sequence header
module vmpa_adjuster #(
  parameter int         FIFO_DEPTH = vmpa_pkg::VMPA_FIFO_DEPTH,
  parameter logic [2:0] MAX_GAP    = vmpa_pkg::VMPA_MAX_GAP
) (
  input  wire logic                clk_sys,
  input  wire logic                rst,
  input  wire logic                ce,
  input  wire vmpa_pkg::vmpa_cfg_t cfg,
  input  wire logic                in_valid,
  output logic                     in_ready,
  input  wire vmpa_pkg::vmpa_in_t  in_beat,
  output vmpa_pkg::vmpa_ts_t       ts,
  output vmpa_pkg::vmpa_stat_t     stat
);

  localparam int LW = $clog2(FIFO_DEPTH) + 1;

  typedef struct packed {
    vmpa_pkg::vmpa_in_state_t        ist;
    logic [7:0]                      ibyte;
    logic [3:0]                      ipkt;
    logic [vmpa_pkg::VMPA_SEQ_W-1:0] pseq;
    logic                            seq_ok;
    logic [6:0]                      fill;
    logic [7:0]                      fbyte;
    vmpa_pkg::vmpa_out_state_t       ost;
    logic [7:0]                      obyte;
    logic [0:11][7:0]                hdr;
    logic                            fat;
    logic [31:0]                     acc;
    logic                            pend;
    vmpa_pkg::vmpa_pcr_t             off;
    vmpa_pkg::vmpa_ts_t              out;
    vmpa_pkg::vmpa_stat_t            stat;
  } vmpa_state_t;

  vmpa_state_t                     s;
  vmpa_state_t                     n;
  logic [vmpa_pkg::VMPA_SEQ_W-1:0] gap;
  logic [2:0]                      gap_c;
  logic [6:0]                      fill_cnt;
  logic                            lossy;
  logic                            f_in_valid;
  logic                            f_in_ready;
  vmpa_pkg::vmpa_word_t            f_in_word;
  logic                            f_out_valid;
  logic                            f_out_ready;
  vmpa_pkg::vmpa_word_t            f_out_word;
  logic [LW-1:0]                   level;
  logic                            carry;
  logic                            is_null;
  logic                            has_pcr;
  vmpa_pkg::vmpa_pcr_t             neg_null;
  vmpa_pkg::vmpa_pcr_t             off_b;
  vmpa_pkg::vmpa_pcr_t             off_sum;
  vmpa_pkg::vmpa_pcr_t             pcr_in;
  vmpa_pkg::vmpa_pcr_t             pcr_out;

  // ==========================================================================
  // Loss detection on the tunnel side
  assign gap      = in_beat.seq - s.pseq - 16'h0001;
  assign gap_c    = (gap > {13'h0, MAX_GAP}) ? MAX_GAP : gap[2:0];
  assign fill_cnt = 7'({4'h0, gap_c} * {3'h0, s.ipkt});
  assign lossy    = in_valid & in_beat.sof & s.seq_ok & (gap != '0)
                    & (s.ist == vmpa_pkg::VMPA_IN_PASS);

  // FIFO fill side: tunnel bytes or substituted null bytes
  assign f_in_valid     = (s.ist == vmpa_pkg::VMPA_IN_FILL)
                          | (in_valid & ~lossy & (s.ist == vmpa_pkg::VMPA_IN_PASS));
  assign f_in_word.sop  = (s.ist == vmpa_pkg::VMPA_IN_FILL) ? (s.fbyte == 8'h00)
                          : (in_beat.sof | (s.ibyte == 8'h00));
  assign f_in_word.data = (s.ist == vmpa_pkg::VMPA_IN_FILL)
                          ? vmpa_pkg::vmpa_null_byte(s.fbyte) : in_beat.data;
  assign in_ready       = (s.ist == vmpa_pkg::VMPA_IN_PASS) & ~lossy & f_in_ready;

  // ==========================================================================
  // De-jitter store
  vmpa_fifo #(
    .W     (9),
    .DEPTH (FIFO_DEPTH),
    .LW    (LW)
  ) u_fifo (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .ce        (ce),
    .in_valid  (f_in_valid),
    .in_ready  (f_in_ready),
    .in_data   (f_in_word),
    .out_valid (f_out_valid),
    .out_ready (f_out_ready),
    .out_data  (f_out_word),
    .level     (level)
  );

  assign f_out_ready = (s.ost == vmpa_pkg::VMPA_OUT_LOAD)
                       | (s.ost == vmpa_pkg::VMPA_OUT_DROP)
                       | ((s.ost == vmpa_pkg::VMPA_OUT_BODY) & s.pend);

  // ==========================================================================
  // Clock-reference arithmetic
  assign is_null = ({s.hdr[1][4:0], s.hdr[2]} == vmpa_pkg::VMPA_NULL_PID);
  assign has_pcr = s.hdr[3][5] & (s.hdr[4] != 8'h00) & s.hdr[5][4];
  assign pcr_in.base = {s.hdr[6], s.hdr[7], s.hdr[8], s.hdr[9], s.hdr[10][7]};
  assign pcr_in.ext  = {s.hdr[10][0], s.hdr[11]};

  // Negated per-null time, for removed nulls
  assign neg_null.base = (cfg.null_pcr.ext == 9'h000) ? (33'h0 - cfg.null_pcr.base)
                         : ~cfg.null_pcr.base;
  assign neg_null.ext  = (cfg.null_pcr.ext == 9'h000) ? 9'h000
                         : 9'(vmpa_pkg::VMPA_EXT_MOD - {1'b0, cfg.null_pcr.ext});
  assign off_b         = (s.ost == vmpa_pkg::VMPA_OUT_DECIDE) ? neg_null : cfg.null_pcr;

  vmpa_pcr_add u_off_add (
    .a   (s.off),
    .b   (off_b),
    .sum (off_sum)
  );

  vmpa_pcr_add u_pcr_add (
    .a   (pcr_in),
    .b   (s.off),
    .sum (pcr_out)
  );

  // ==========================================================================
  // Next-state logic of both sides
  always_comb
  begin
    n           = s;
    n.out.valid = 1'b0;
    n.out.sop   = 1'b0;
    n.stat      = '0;
    // Rate pacing accumulator; a pending byte slot survives until used
    {carry, n.acc} = {1'b0, s.acc} + {1'b0, cfg.rate_step};
    n.pend         = s.pend | carry;

    // Tunnel side
    case (s.ist)
      vmpa_pkg::VMPA_IN_PASS:
      begin
        if (lossy)
        begin
          n.stat.loss = 1'b1;
          n.pseq      = in_beat.seq - 16'h0001;  // Next look at this frame sees no gap
          if (fill_cnt != 7'h00)
          begin
            n.ist   = vmpa_pkg::VMPA_IN_FILL;
            n.fill  = fill_cnt;
            n.fbyte = 8'h00;
          end
        end
        else if (in_valid & f_in_ready)
        begin
          if (in_beat.sof)
          begin
            n.ibyte  = 8'h01;
            n.ipkt   = 4'h0;
            n.pseq   = in_beat.seq;
            n.seq_ok = 1'b1;
          end
          else if (s.ibyte == vmpa_pkg::VMPA_PKT_LAST)
          begin
            n.ibyte = 8'h00;
            n.ipkt  = s.ipkt + 4'h1;
          end
          else
          begin
            n.ibyte = s.ibyte + 8'h01;
          end
        end
      end
      vmpa_pkg::VMPA_IN_FILL:
      begin
        if (f_in_ready)
        begin
          if (s.fbyte == vmpa_pkg::VMPA_PKT_LAST)
          begin
            n.fbyte = 8'h00;
            n.fill  = s.fill - 7'h01;
            if (s.fill == 7'h01)
              n.ist = vmpa_pkg::VMPA_IN_PASS;
          end
          else
          begin
            n.fbyte = s.fbyte + 8'h01;
          end
        end
      end
      default:
      begin
        n.ist = vmpa_pkg::VMPA_IN_PASS;
      end
    endcase

    // Output side
    case (s.ost)
      vmpa_pkg::VMPA_OUT_WAIT:
      begin
        if (level >= LW'(vmpa_pkg::VMPA_PREFILL))
        begin
          n.ost   = vmpa_pkg::VMPA_OUT_LOAD;
          n.obyte = 8'h00;
        end
      end
      vmpa_pkg::VMPA_OUT_LOAD:
      begin
        // Bytes ahead of a packet start are discarded to realign
        if (f_out_valid & ((s.obyte != 8'h00) | f_out_word.sop))
        begin
          n.hdr[s.obyte[3:0]] = f_out_word.data;
          if (s.obyte == vmpa_pkg::VMPA_HDR_LAST)
            n.ost = vmpa_pkg::VMPA_OUT_DECIDE;
          else
            n.obyte = s.obyte + 8'h01;
        end
      end
      vmpa_pkg::VMPA_OUT_DECIDE:
      begin
        if (cfg.async_mode & is_null & s.fat)
        begin
          n.ost      = vmpa_pkg::VMPA_OUT_DROP;
          n.obyte    = vmpa_pkg::VMPA_BODY_FIRST;
          n.off      = off_sum;
          n.stat.del = 1'b1;
        end
        else
        begin
          // Synchronous mode leaves the reference untouched
          if (cfg.async_mode & has_pcr)
          begin
            n.hdr[6]  = pcr_out.base[32:25];
            n.hdr[7]  = pcr_out.base[24:17];
            n.hdr[8]  = pcr_out.base[16:9];
            n.hdr[9]  = pcr_out.base[8:1];
            n.hdr[10] = {pcr_out.base[0], s.hdr[10][6:1], pcr_out.ext[8]};
            n.hdr[11] = pcr_out.ext[7:0];
          end
          n.ost   = vmpa_pkg::VMPA_OUT_HEAD;
          n.obyte = 8'h00;
        end
      end
      vmpa_pkg::VMPA_OUT_HEAD:
      begin
        if (s.pend)
        begin
          n.pend      = carry;
          n.out.valid = 1'b1;
          n.out.sop   = (s.obyte == 8'h00);
          n.out.data  = s.hdr[s.obyte[3:0]];
          if (s.obyte == vmpa_pkg::VMPA_HDR_LAST)
          begin
            n.ost   = vmpa_pkg::VMPA_OUT_BODY;
            n.obyte = vmpa_pkg::VMPA_BODY_FIRST;
          end
          else
          begin
            n.obyte = s.obyte + 8'h01;
          end
        end
      end
      vmpa_pkg::VMPA_OUT_BODY:
      begin
        if (s.pend & f_out_valid)
        begin
          n.pend      = carry;
          n.out.valid = 1'b1;
          n.out.data  = f_out_word.data;
          if (s.obyte == vmpa_pkg::VMPA_PKT_LAST)
            n.ost = vmpa_pkg::VMPA_OUT_NEXT;
          else
            n.obyte = s.obyte + 8'h01;
        end
      end
      vmpa_pkg::VMPA_OUT_DROP:
      begin
        if (f_out_valid)
        begin
          if (s.obyte == vmpa_pkg::VMPA_PKT_LAST)
            n.ost = vmpa_pkg::VMPA_OUT_NEXT;
          else
            n.obyte = s.obyte + 8'h01;
        end
      end
      vmpa_pkg::VMPA_OUT_GEN:
      begin
        if (s.pend)
        begin
          n.pend      = carry;
          n.out.valid = 1'b1;
          n.out.sop   = (s.obyte == 8'h00);
          n.out.data  = vmpa_pkg::vmpa_null_byte(s.obyte);
          if (s.obyte == vmpa_pkg::VMPA_PKT_LAST)
            n.ost = vmpa_pkg::VMPA_OUT_NEXT;
          else
            n.obyte = s.obyte + 8'h01;
        end
      end
      vmpa_pkg::VMPA_OUT_NEXT:
      begin
        // Packet boundary: pick the next source from the buffer level
        n.fat   = (level >= LW'(vmpa_pkg::VMPA_HIGH_MARK));
        n.obyte = 8'h00;
        if (cfg.async_mode ? (level < LW'(vmpa_pkg::VMPA_LOW_MARK)) : (level == '0))
        begin
          n.ost = vmpa_pkg::VMPA_OUT_GEN;
          if (cfg.async_mode)
          begin
            n.off      = off_sum;
            n.stat.ins = 1'b1;
          end
        end
        else
        begin
          n.ost = vmpa_pkg::VMPA_OUT_LOAD;
        end
      end
      default:
      begin
        n.ost = vmpa_pkg::VMPA_OUT_WAIT;
      end
    endcase
  end

  // ==========================================================================
  // State register, frozen while the clock enable is low
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      s      <= '0;
      s.acc  <= vmpa_pkg::VMPA_ACC_RST;
      s.ist  <= vmpa_pkg::VMPA_IN_PASS;
      s.ost  <= vmpa_pkg::VMPA_OUT_WAIT;
    end
    else if (ce)
    begin
      s <= n;
    end
  end

  assign ts   = s.out;
  assign stat = s.stat;

endmodule : vmpa_adjuster

/* vmpa_adjuster_asserts.sv */
// Port assertions of the null and clock-reference adjuster
`timescale 1ns/10ps
module vmpa_adjuster_chk (
  input wire logic                 clk_sys,
  input wire logic                 rst,
  input wire logic                 ce,
  input wire vmpa_pkg::vmpa_cfg_t  cfg,
  input wire logic                 in_valid,
  input wire logic                 in_ready,
  input wire vmpa_pkg::vmpa_in_t   in_beat,
  input wire vmpa_pkg::vmpa_ts_t   ts,
  input wire vmpa_pkg::vmpa_stat_t stat
);
  // ==========================================================================
  // Helpers
  logic [7:0] pos_q;
  logic [4:0] fill_q;

  // Output byte position and saturating count of taken beats
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      pos_q  <= 8'h00;
      fill_q <= 5'h00;
    end
    else
    begin
      if (ce && ts.valid)
        pos_q <= (pos_q == 8'hbb) ? 8'h00 : pos_q + 8'h01;
      if (ce && in_valid && in_ready && fill_q != 5'h10)
        fill_q <= fill_q + 5'h01;
    end
  end

  // ==========================================================================
  // Assertions
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);

  loss_cause_a: assert property (
    stat.loss |-> $past(in_valid && in_beat.sof && !in_ready))
    else $error("loss pulse without a held frame start");
  loss_pulse_a: assert property (
    stat.loss |=> !stat.loss)
    else $error("loss pulse longer than one cycle");
  sop_pos_a: assert property (
    ts.valid |-> (ts.sop == (pos_q == 8'h00)))
    else $error("packet start not every 188 bytes");
  sop_sync_a: assert property (
    ts.valid && ts.sop |-> ts.data == 8'h47)
    else $error("packet start without sync byte");
  sop_alone_a: assert property (
    ts.sop |-> ts.valid)
    else $error("packet start flag without valid");
  prefill_wait_a: assert property (
    ts.valid |-> fill_q == 5'h10)
    else $error("output before buffer prefill");
  ins_edge_a: assert property (
    stat.ins |-> pos_q == 8'h00 || pos_q == 8'hbb)
    else $error("null added inside a packet");
  del_mode_a: assert property (
    stat.del |-> cfg.async_mode && (pos_q == 8'h00 || pos_q == 8'hbb))
    else $error("null removed out of place or mode");
endmodule : vmpa_adjuster_chk

bind vmpa_adjuster vmpa_adjuster_chk i_chk (.clk_sys(clk_sys), .rst(rst), .ce(ce), .cfg(cfg),
  .in_valid(in_valid), .in_ready(in_ready), .in_beat(in_beat), .ts(ts), .stat(stat));

/* vmpa_core_model.sv */
// Model of the access core sending tunnel frames
`timescale 1ns/10ps
module vmpa_core_model (
  input  wire logic          clk_sys,
  input  wire logic          in_ready,
  output logic               in_valid,
  output vmpa_pkg::vmpa_in_t in_beat
);
  logic slow;

  // Idle at start
  initial
  begin
    in_valid = 1'b0;
    in_beat  = '0;
    slow     = 1'b0;
  end

  // One frame, each beat held until taken
  task automatic send_frame(input logic [15:0] seq, input logic [7:0] b[$]);
    logic rdy;
    for (int i = 0; i < b.size(); i++)
    begin
      in_valid <= 1'b1;
      in_beat  <= '{sof: (i == 0), seq: seq, data: b[i]};
      rdy = 1'b0;
      while (!rdy)
      begin
        @(negedge clk_sys);
        rdy = in_ready;
        @(posedge clk_sys);
      end
      if (slow)
      begin
        in_valid     <= 1'b0;
        in_beat.data <= ~b[i];
        repeat (1 + $urandom_range(7)) @(posedge clk_sys);
      end
    end
  endtask : send_frame

  // Release the stream, data inverted
  task automatic idle();
    in_valid     <= 1'b0;
    in_beat.data <= ~in_beat.data;
  endtask : idle
endmodule : vmpa_core_model

/* vmpa_fifo.sv */
// Parameterised valid/ready FIFO used as the de-jitter store
`timescale 1ns/10ps
module vmpa_fifo #(
  parameter int W     = 9,
  parameter int DEPTH = 32,
  parameter int LW    = $clog2(DEPTH) + 1
) (
  input  wire logic          clk_sys,
  input  wire logic          rst,
  input  wire logic          ce,
  input  wire logic          in_valid,
  output logic               in_ready,
  input  wire logic [W-1:0]  in_data,
  output logic               out_valid,
  input  wire logic          out_ready,
  output logic [W-1:0]       out_data,
  output logic [LW-1:0]      level
);

  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wr;
    logic [AW-1:0]           rd;
    logic [LW-1:0]           cnt;
  } vmpa_fifo_state_t;

  vmpa_fifo_state_t s;
  vmpa_fifo_state_t n;
  logic             push;
  logic             pop;

  // ==========================================================================
  // Handshake
  assign in_ready  = (s.cnt != LW'(DEPTH));
  assign out_valid = (s.cnt != '0);
  assign out_data  = s.mem[s.rd];
  assign level     = s.cnt;
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // Pointer and count update
  always_comb
  begin
    n = s;
    if (push)
    begin
      n.mem[s.wr] = in_data;
      n.wr        = (s.wr == AW'(DEPTH - 1)) ? '0 : s.wr + 1'b1;
    end
    if (pop)
    begin
      n.rd = (s.rd == AW'(DEPTH - 1)) ? '0 : s.rd + 1'b1;
    end
    n.cnt = s.cnt + LW'(push) - LW'(pop);
  end

  // State register
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      s <= '0;
    else if (ce)
      s <= n;
  end

endmodule : vmpa_fifo

/* vmpa_pcr_add.sv */
// Adds two clock-reference values in base plus extension form
`timescale 1ns/10ps
module vmpa_pcr_add (
  input  wire vmpa_pkg::vmpa_pcr_t a,
  input  wire vmpa_pkg::vmpa_pcr_t b,
  output vmpa_pkg::vmpa_pcr_t      sum
);

  logic [9:0] ext_s;
  logic       wrap;

  // ==========================================================================
  // Extension wraps into the base, base wraps modulo its width
  assign ext_s    = {1'b0, a.ext} + {1'b0, b.ext};
  assign wrap     = (ext_s >= vmpa_pkg::VMPA_EXT_MOD);
  assign sum.ext  = wrap ? 9'(ext_s - vmpa_pkg::VMPA_EXT_MOD) : ext_s[8:0];
  assign sum.base = a.base + b.base + {32'h0, wrap};

endmodule : vmpa_pcr_add

/* vmpa_pkg.sv */
// Shared constants, types and helpers of the null and clock-reference adjuster
package vmpa_pkg;

  // ==========================================================================
  // Transport packet layout
  localparam logic [7:0]  VMPA_PKT_LAST   = 8'hbb;  // Last byte index of a 188-byte packet
  localparam logic [7:0]  VMPA_HDR_LAST   = 8'h0b;  // Last index of the header bytes held for restamping
  localparam logic [7:0]  VMPA_BODY_FIRST = 8'h0c;
  localparam logic [7:0]  VMPA_SYNC_BYTE  = 8'h47;
  localparam logic [12:0] VMPA_NULL_PID   = 13'h1fff;
  localparam logic [9:0]  VMPA_EXT_MOD    = 10'h12c;  // Reference extension wraps at 300

  // ==========================================================================
  // Tunnel framing and buffering
  localparam int          VMPA_SEQ_W      = 16;
  localparam int          VMPA_FIFO_DEPTH = 32;
  localparam int          VMPA_PREFILL    = 16;  // Fill before output starts
  localparam int          VMPA_LOW_MARK   = 4;   // Below this a null is added in async mode; sync mode adds one only at level 0
  localparam int          VMPA_HIGH_MARK  = 28;  // At or above this a null is removed in async mode
  localparam logic [2:0]  VMPA_MAX_GAP    = 3'h3;  // Most lost frames refilled per gap
  localparam logic [31:0] VMPA_ACC_RST    = 32'h0;

  // ==========================================================================
  // Types
  typedef enum logic [0:0] {
    VMPA_IN_PASS = 1'b0,
    VMPA_IN_FILL = 1'b1
  } vmpa_in_state_t;

  typedef enum logic [2:0] {
    VMPA_OUT_WAIT   = 3'b000,
    VMPA_OUT_LOAD   = 3'b001,
    VMPA_OUT_DECIDE = 3'b010,
    VMPA_OUT_HEAD   = 3'b011,
    VMPA_OUT_BODY   = 3'b100,
    VMPA_OUT_DROP   = 3'b101,
    VMPA_OUT_GEN    = 3'b110,
    VMPA_OUT_NEXT   = 3'b111
  } vmpa_out_state_t;

  typedef struct packed {
    logic [32:0] base;
    logic [8:0]  ext;
  } vmpa_pcr_t;

  typedef struct packed {
    logic            async_mode;
    logic [31:0]     rate_step;  // Byte rate as a fraction of the clock, 2^32 scale
    vmpa_pcr_t       null_pcr;   // Reference time of one packet at that rate
  } vmpa_cfg_t;

  typedef struct packed {
    logic                  sof;
    logic [VMPA_SEQ_W-1:0] seq;
    logic [7:0]            data;
  } vmpa_in_t;

  typedef struct packed {
    logic       sop;
    logic [7:0] data;
  } vmpa_word_t;

  typedef struct packed {
    logic       valid;
    logic       sop;
    logic [7:0] data;
  } vmpa_ts_t;

  typedef struct packed {
    logic loss;
    logic ins;
    logic del;
  } vmpa_stat_t;

  // Byte of a null packet by index
  function automatic logic [7:0] vmpa_null_byte(input logic [7:0] idx);
    case (idx)
      8'h00:   vmpa_null_byte = VMPA_SYNC_BYTE;
      8'h01:   vmpa_null_byte = {3'h0, VMPA_NULL_PID[12:8]};
      8'h02:   vmpa_null_byte = VMPA_NULL_PID[7:0];
      8'h03:   vmpa_null_byte = 8'h10;
      default: vmpa_null_byte = 8'hff;
    endcase
  endfunction : vmpa_null_byte

endpackage : vmpa_pkg
